/* hdl/rx_filter_pkg.sv */
package rx_filter_pkg;

  // register offsets on the serial control port
  localparam logic [5:0] OFS_DELIM_HIGH = 6'h04;
  localparam logic [5:0] OFS_DELIM_LOW = 6'h05;
  localparam logic [5:0] OFS_SIZE_LIMIT = 6'h06;
  localparam logic [5:0] OFS_FILTER_CTRL = 6'h07;
  localparam logic [5:0] OFS_FORMAT_CTRL = 6'h08;
  localparam logic [5:0] OFS_NODE_ADDR = 6'h09;
  localparam logic [5:0] OFS_SLOT_INDEX = 6'h0A;
  localparam logic [5:0] OFS_ENGINE_STATUS = 6'h35;

  // values after reset
  localparam logic [7:0] RST_DELIM_HIGH = 8'hD3;
  localparam logic [7:0] RST_DELIM_LOW = 8'h91;
  localparam logic [7:0] RST_SIZE_LIMIT = 8'hFF;
  localparam logic [7:0] RST_FILTER_CTRL = 8'h04;
  localparam logic [7:0] RST_FORMAT_CTRL = 8'h45;
  localparam logic [7:0] RST_NODE_ADDR = 8'h00;
  localparam logic [7:0] RST_SLOT_INDEX = 8'h00;

  // writable bits; the rest read as zero
  localparam logic [7:0] MASK_FILTER_CTRL = 8'hEF;
  localparam logic [7:0] MASK_FORMAT_CTRL = 8'h77;

  // field positions
  localparam int POS_DROP_ON_CHECK_FAIL = 3;
  localparam int POS_TRAILER_BYTES_ENABLE = 2;
  localparam int POS_NODE_MATCH_LSB = 0;
  localparam int POS_RX_OUTPUT_FORMAT_LSB = 4;
  localparam int POS_CHECK_ENABLE = 2;
  localparam int POS_SIZE_POLICY_LSB = 0;

  // serial header layout
  localparam int POS_HDR_READ = 7;
  localparam int POS_HDR_BURST = 6;

  // field encodings
  localparam logic [1:0] SIZE_FIXED = 2'b00;
  localparam logic [1:0] SIZE_VARIABLE = 2'b01;
  localparam logic [1:0] SIZE_UNBOUNDED = 2'b10;
  localparam logic [1:0] MATCH_NONE = 2'b00;
  localparam logic [1:0] MATCH_BCAST_ZERO = 2'b10;
  localparam logic [1:0] MATCH_BCAST_BOTH = 2'b11;
  localparam logic [1:0] FMT_FIFO = 2'b00;
  localparam logic [1:0] FMT_SYNC_SERIAL = 2'b01;
  localparam logic [1:0] FMT_ASYNC_SERIAL = 2'b11;
  localparam logic [7:0] BCAST_ZERO = 8'h00;
  localparam logic [7:0] BCAST_ONES = 8'hFF;

  // frame checksum
  localparam logic [15:0] CHECK_POLY = 16'h8005;
  localparam logic [15:0] CHECK_INIT = 16'hFFFF;
  localparam logic [7:0] CHECK_BYTES = 8'h02;

  // receive buffer
  localparam int RX_FIFO_DEPTH = 32;
  localparam int RX_FIFO_WIDTH = 8;

  typedef struct packed {
    logic [7:0] delim_high;
    logic [7:0] delim_low;
    logic [7:0] size_limit;
    logic [7:0] filter_ctrl;
    logic [7:0] format_ctrl;
    logic [7:0] node_addr;
    logic [7:0] slot_index;
  } cfg_type;

endpackage

/* hdl/rx_byte_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic CLK, // clock
  input wire logic RST, // synchronous reset
  input wire logic flush, // drop every stored word
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // output word held
  input wire logic out_ready, // output word taken
  output logic [WIDTH-1:0] out_data // output word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic out_valid_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  // output register refills as soon as it is empty or being taken
  assign pop = (count_ff != '0) && (!out_valid_ff || out_ready);
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;

  always_ff @(posedge CLK)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST || flush)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST || flush)
    begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end
    else if (pop)
    begin
      out_valid_ff <= 1'b1;
      out_data_ff <= mem[rd_ptr_ff];
    end
    else if (out_ready)
    begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule // rx_byte_fifo
`default_nettype wire

/* hdl/rx_frame_filter.sv */
// Summary of operation
// R01: delimiter upper byte register, resets to D3
// R02: delimiter lower byte register, resets to 91
// R03: fixed policy: limit register gives exact size
// R04: variable policy: limit register is maximum size
// R05: host never writes zero size limit
// R06: checksum failure flushes buffer when enabled
// R07: host keeps one short frame buffered
// R08: trailer enable appends two status bytes; with checksum disabled they overflow the two byte stage
// R09: trailer carries signal strength and check result
// R10: match select: none, exact, +00, +00/FF
// R11: compare address byte against node address
// R12: output format: buffer, sync serial, async serial
// R13: serial formats bypass buffer onto output pin
// R14: policy 00 selects fixed size frames
// R15: policy 01 takes size from first byte
// R16: policy 10 receives without length limit
// R17: eight bit channel index register, reset zero
// R18: address mismatch drops frame before buffering
// R19: length byte above limit drops the frame
`timescale 1ns/1ps
`default_nettype none
module rx_frame_filter #(
  parameter int FIFO_DEPTH = rx_filter_pkg::RX_FIFO_DEPTH
) (
  input wire logic CLK, // 125 MHz clock
  input wire logic RST, // synchronous reset, high
  input wire logic SCLK, // control port serial clock
  input wire logic CS_N, // control port select, low
  input wire logic MOSI, // control port data in
  output logic MISO, // control port data out
  output logic MISO_OE_N, // data out enable, low drives
  input wire logic RX_BIT, // demodulated bit
  input wire logic RX_BIT_VALID, // bit strobe
  input wire logic RX_ABORT, // carrier lost, ends any frame
  input wire logic [7:0] RX_RSSI, // signal strength of current frame
  output logic [7:0] FIFO_DATA, // received byte
  output logic FIFO_VALID, // received byte present
  input wire logic FIFO_READY, // received byte taken
  output logic GENERAL_OUTPUT_PIN_ZERO, // serial data out
  output logic GENERAL_OUTPUT_PIN_CLOCK, // serial bit strobe
  output logic [7:0] RF_SLOT_NUMBER // channel index to synthesizer
);
  typedef enum logic [2:0] {HUNT, LEN, ADDR, BODY, CHK} rx_state_type;

  rx_filter_pkg::cfg_type cfg_ff;
  rx_state_type state_ff;
  rx_state_type nxt_state;
  logic [15:0] shift_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] rem_ff;
  logic [7:0] nxt_rem;
  logic [7:0] len_ff;
  logic [7:0] nxt_len;
  logic [15:0] crc_ff;
  logic [15:0] crc_step;
  logic [7:0] stage_ff [2];
  logic [1:0] stage_cnt_ff;
  logic overflow_ff;
  logic last_ok_ff;
  logic [7:0] rx_byte;
  logic byte_done;
  logic active;
  logic [1:0] size_policy;
  logic [1:0] match_sel;
  logic check_en;
  logic filter_on;
  logic addr_ok;
  logic [1:0] enq_n;
  logic [7:0] enq_a;
  logic [7:0] enq_b;
  logic do_flush;
  logic done_ok;
  logic finish;
  logic fifo_in_ready;
  logic stage_pop;
  // control port
  logic sclk_q_ff;
  logic [7:0] sin_ff;
  logic [2:0] sbit_ff;
  logic hdr_ff;
  logic rd_ff;
  logic burst_ff;
  logic [5:0] saddr_ff;
  logic load_pend_ff;
  logic [7:0] tx_ff;
  logic miso_ff;
  logic miso_oe_n_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] sbyte;
  logic sbyte_done;
  logic [7:0] rdata;
  logic status_clear;
  logic gpo0_ff;
  logic gpo_clk_ff;
  logic [7:0] slot_ff;

  assign size_policy = cfg_ff.format_ctrl[rx_filter_pkg::POS_SIZE_POLICY_LSB +: 2];
  assign check_en = cfg_ff.format_ctrl[rx_filter_pkg::POS_CHECK_ENABLE];
  assign match_sel = cfg_ff.filter_ctrl[rx_filter_pkg::POS_NODE_MATCH_LSB +: 2];
  assign filter_on = (match_sel != rx_filter_pkg::MATCH_NONE); // R10
  // serial formats leave the frame engine parked in hunt
  assign active = (cfg_ff.format_ctrl[rx_filter_pkg::POS_RX_OUTPUT_FORMAT_LSB +: 2]
                   == rx_filter_pkg::FMT_FIFO); // R12 R13
  assign rx_byte = {shift_ff[6:0], RX_BIT};
  assign byte_done = RX_BIT_VALID && (bit_cnt_ff == 3'd7);

  // address filter with optional broadcast values
  always_comb
  begin
    addr_ok = (rx_byte == cfg_ff.node_addr); // R11
    if ((match_sel == rx_filter_pkg::MATCH_BCAST_ZERO || match_sel == rx_filter_pkg::MATCH_BCAST_BOTH)
        && rx_byte == rx_filter_pkg::BCAST_ZERO)
      addr_ok = 1'b1; // R10 R11
    if (match_sel == rx_filter_pkg::MATCH_BCAST_BOTH && rx_byte == rx_filter_pkg::BCAST_ONES)
      addr_ok = 1'b1; // R10 R11
  end

  // running checksum; feeding the received check bytes through it leaves zero
  always_comb
  begin
    crc_step = {crc_ff[14:0], 1'b0};
    if (crc_ff[15] ^ RX_BIT)
      crc_step = crc_step ^ rx_filter_pkg::CHECK_POLY;
  end

  // frame engine decisions, evaluated on each received bit
  always_comb
  begin
    nxt_state = state_ff;
    nxt_rem = rem_ff;
    nxt_len = len_ff;
    enq_n = 2'd0;
    enq_a = rx_byte;
    enq_b = rx_byte;
    finish = 1'b0;
    done_ok = 1'b1;
    if (!active || (RX_ABORT && state_ff != HUNT))
    begin
      nxt_state = HUNT;
    end
    else if (state_ff == HUNT)
    begin
      if (RX_BIT_VALID && {shift_ff[14:0], RX_BIT} == {cfg_ff.delim_high, cfg_ff.delim_low}) // R01 R02
      begin
        nxt_rem = cfg_ff.size_limit; // R03
        if (size_policy == rx_filter_pkg::SIZE_VARIABLE)
          nxt_state = LEN; // R15
        else if (filter_on)
          nxt_state = ADDR; // R14 R16
        else
          nxt_state = BODY; // R14 R16
      end
    end
    else if (byte_done)
    begin
      case (state_ff)
        LEN:
        begin
          nxt_len = rx_byte; // R15
          nxt_rem = rx_byte;
          if (rx_byte > cfg_ff.size_limit)
            nxt_state = HUNT; // R04 R19
          else if (rx_byte == 8'h00)
          begin
            enq_n = 2'd1;
            nxt_state = check_en ? CHK : HUNT;
            finish = !check_en;
          end
          else if (filter_on)
            nxt_state = ADDR;
          else
          begin
            enq_n = 2'd1;
            nxt_state = BODY;
          end
        end
        ADDR:
        begin
          if (!addr_ok)
            nxt_state = HUNT; // R18
          else
          begin
            // length byte was held back so a rejected frame leaves no trace
            enq_n = (size_policy == rx_filter_pkg::SIZE_VARIABLE) ? 2'd2 : 2'd1; // R18
            enq_a = (size_policy == rx_filter_pkg::SIZE_VARIABLE) ? len_ff : rx_byte;
            nxt_rem = rem_ff - 8'd1;
            if (rem_ff == 8'd1 && size_policy != rx_filter_pkg::SIZE_UNBOUNDED)
            begin
              nxt_state = check_en ? CHK : HUNT;
              finish = !check_en;
            end
            else
              nxt_state = BODY;
          end
        end
        BODY:
        begin
          enq_n = 2'd1;
          nxt_rem = rem_ff - 8'd1;
          if (rem_ff == 8'd1 && size_policy != rx_filter_pkg::SIZE_UNBOUNDED) // R03 R04 R16
          begin
            nxt_state = check_en ? CHK : HUNT;
            finish = !check_en;
          end
        end
        CHK:
        begin
          nxt_rem = rem_ff - 8'd1;
          if (rem_ff == 8'd1)
          begin
            nxt_state = HUNT;
            finish = 1'b1;
            done_ok = (crc_step == 16'h0000);
          end
        end
        default:
        begin
          nxt_state = HUNT;
        end
      endcase
      if (nxt_state == CHK && state_ff != CHK)
        nxt_rem = rx_filter_pkg::CHECK_BYTES;
    end
    do_flush = finish && !done_ok && cfg_ff.filter_ctrl[rx_filter_pkg::POS_DROP_ON_CHECK_FAIL]; // R06
    if (finish && !do_flush && cfg_ff.filter_ctrl[rx_filter_pkg::POS_TRAILER_BYTES_ENABLE]) // R08
    begin
      enq_a = (enq_n == 2'd0) ? RX_RSSI : enq_a; // R09
      enq_n = enq_n + 2'd2;
      enq_b = {done_ok, 7'h00}; // R09
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      state_ff <= HUNT;
      rem_ff <= '0;
      len_ff <= '0;
      last_ok_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      rem_ff <= nxt_rem;
      len_ff <= nxt_len;
      if (finish)
        last_ok_ff <= done_ok;
    end
  end

  // bit assembly and checksum
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      shift_ff <= '0;
      bit_cnt_ff <= '0;
      crc_ff <= rx_filter_pkg::CHECK_INIT;
    end
    else if (RX_BIT_VALID)
    begin
      shift_ff <= {shift_ff[14:0], RX_BIT};
      bit_cnt_ff <= (state_ff == HUNT) ? 3'd0 : bit_cnt_ff + 3'd1;
      crc_ff <= (state_ff == HUNT) ? rx_filter_pkg::CHECK_INIT : crc_step;
    end
  end

  // two byte staging ahead of the buffer; a stalled buffer stalls the stage
  assign stage_pop = (stage_cnt_ff != 2'd0) && fifo_in_ready;

  always_ff @(posedge CLK)
  begin
    if (RST || do_flush)
    begin
      stage_cnt_ff <= '0;
      stage_ff[0] <= '0;
      stage_ff[1] <= '0;
    end
    else
    begin
      // trailer with a trailing payload byte needs three slots; the signal strength byte is never staged, which sets overflow
      case ({stage_pop, stage_cnt_ff})
        3'b1_01, 3'b0_00:
        begin
          stage_ff[0] <= enq_a;
          stage_ff[1] <= enq_b;
          stage_cnt_ff <= enq_n;
        end
        3'b1_10, 3'b0_01:
        begin
          stage_ff[0] <= stage_pop ? stage_ff[1] : stage_ff[0];
          stage_ff[1] <= enq_a;
          stage_cnt_ff <= (enq_n != 2'd0) ? 2'd2 : 2'd1;
        end
        default:
        begin
          stage_cnt_ff <= stage_cnt_ff;
        end
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      overflow_ff <= 1'b0;
    else if ({1'b0, stage_cnt_ff} - {2'b00, stage_pop} + {1'b0, enq_n} > 3'd2)
      overflow_ff <= 1'b1;
    else if (status_clear)
      overflow_ff <= 1'b0;
  end

  rx_byte_fifo #(
    .WIDTH(rx_filter_pkg::RX_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .RST(RST),
    .flush(do_flush), // R06 R07
    .in_valid(stage_cnt_ff != 2'd0),
    .in_ready(fifo_in_ready),
    .in_data(stage_ff[0]),
    .out_valid(FIFO_VALID),
    .out_ready(FIFO_READY),
    .out_data(FIFO_DATA)
  );

  // serial output formats
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      gpo0_ff <= 1'b0;
      gpo_clk_ff <= 1'b0;
    end
    else
    begin
      case (cfg_ff.format_ctrl[rx_filter_pkg::POS_RX_OUTPUT_FORMAT_LSB +: 2])
        rx_filter_pkg::FMT_SYNC_SERIAL:
        begin
          gpo0_ff <= RX_BIT_VALID ? RX_BIT : gpo0_ff; // R13
          gpo_clk_ff <= RX_BIT_VALID;
        end
        rx_filter_pkg::FMT_ASYNC_SERIAL:
        begin
          gpo0_ff <= RX_BIT; // R13
          gpo_clk_ff <= 1'b0;
        end
        default:
        begin
          gpo0_ff <= 1'b0;
          gpo_clk_ff <= 1'b0;
        end
      endcase
    end
  end

  // control port, mode 0, sampled on the system clock
  assign sclk_rise = !CS_N && SCLK && !sclk_q_ff;
  assign sclk_fall = !CS_N && !SCLK && sclk_q_ff;
  assign sbyte = {sin_ff[6:0], MOSI};
  assign sbyte_done = sclk_rise && (sbit_ff == 3'd7);
  assign status_clear = sbyte_done && !hdr_ff && !rd_ff && saddr_ff == rx_filter_pkg::OFS_ENGINE_STATUS;

  always_comb
  begin
    case (saddr_ff)
      rx_filter_pkg::OFS_DELIM_HIGH: rdata = cfg_ff.delim_high;
      rx_filter_pkg::OFS_DELIM_LOW: rdata = cfg_ff.delim_low;
      rx_filter_pkg::OFS_SIZE_LIMIT: rdata = cfg_ff.size_limit;
      rx_filter_pkg::OFS_FILTER_CTRL: rdata = cfg_ff.filter_ctrl;
      rx_filter_pkg::OFS_FORMAT_CTRL: rdata = cfg_ff.format_ctrl;
      rx_filter_pkg::OFS_NODE_ADDR: rdata = cfg_ff.node_addr;
      rx_filter_pkg::OFS_SLOT_INDEX: rdata = cfg_ff.slot_index;
      rx_filter_pkg::OFS_ENGINE_STATUS: rdata = {overflow_ff, last_ok_ff, FIFO_VALID, 2'b00, 3'(state_ff)};
      default: rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (RST || CS_N)
    begin
      sbit_ff <= '0;
      hdr_ff <= 1'b1;
      rd_ff <= 1'b0;
      burst_ff <= 1'b0;
      saddr_ff <= '0;
      sin_ff <= '0;
    end
    else if (sclk_rise)
    begin
      sin_ff <= sbyte;
      sbit_ff <= sbit_ff + 3'd1;
      if (sbit_ff == 3'd7 && hdr_ff)
      begin
        hdr_ff <= 1'b0;
        rd_ff <= sbyte[rx_filter_pkg::POS_HDR_READ];
        burst_ff <= sbyte[rx_filter_pkg::POS_HDR_BURST];
        saddr_ff <= sbyte[5:0];
      end
      else if (sbit_ff == 3'd7)
      begin
        // single access ends after one data byte; burst walks upward
        hdr_ff <= !burst_ff;
        saddr_ff <= saddr_ff + 6'd1;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      cfg_ff <= '{rx_filter_pkg::RST_DELIM_HIGH, rx_filter_pkg::RST_DELIM_LOW, rx_filter_pkg::RST_SIZE_LIMIT,
                  rx_filter_pkg::RST_FILTER_CTRL, rx_filter_pkg::RST_FORMAT_CTRL, rx_filter_pkg::RST_NODE_ADDR,
                  rx_filter_pkg::RST_SLOT_INDEX}; // R01 R02 R03 R17
    else if (sbyte_done && !hdr_ff && !rd_ff)
    begin
      case (saddr_ff)
        rx_filter_pkg::OFS_DELIM_HIGH: cfg_ff.delim_high <= sbyte; // R01
        rx_filter_pkg::OFS_DELIM_LOW: cfg_ff.delim_low <= sbyte; // R02
        rx_filter_pkg::OFS_SIZE_LIMIT: cfg_ff.size_limit <= sbyte;
        rx_filter_pkg::OFS_FILTER_CTRL: cfg_ff.filter_ctrl <= sbyte & rx_filter_pkg::MASK_FILTER_CTRL;
        rx_filter_pkg::OFS_FORMAT_CTRL: cfg_ff.format_ctrl <= sbyte & rx_filter_pkg::MASK_FORMAT_CTRL;
        rx_filter_pkg::OFS_NODE_ADDR: cfg_ff.node_addr <= sbyte; // R11
        rx_filter_pkg::OFS_SLOT_INDEX: cfg_ff.slot_index <= sbyte; // R17
        default: cfg_ff <= cfg_ff;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      sclk_q_ff <= 1'b0;
      load_pend_ff <= 1'b0;
      tx_ff <= '0;
      miso_ff <= 1'b0;
      miso_oe_n_ff <= 1'b1;
      slot_ff <= rx_filter_pkg::RST_SLOT_INDEX;
    end
    else
    begin
      sclk_q_ff <= SCLK;
      miso_oe_n_ff <= CS_N;
      slot_ff <= cfg_ff.slot_index; // R17
      if (CS_N)
      begin
        load_pend_ff <= 1'b0;
        miso_ff <= 1'b0;
      end
      else if (sbyte_done)
        load_pend_ff <= 1'b1;
      else if (sclk_fall)
      begin
        // read data is presented after the byte boundary fall, ahead of its first rise
        load_pend_ff <= 1'b0;
        if (load_pend_ff && rd_ff)
        begin
          miso_ff <= rdata[7];
          tx_ff <= {rdata[6:0], 1'b0};
        end
        else
        begin
          miso_ff <= tx_ff[7];
          tx_ff <= {tx_ff[6:0], 1'b0};
        end
      end
    end
  end

  assign MISO = miso_ff;
  assign MISO_OE_N = miso_oe_n_ff;
  assign GENERAL_OUTPUT_PIN_ZERO = gpo0_ff;
  assign GENERAL_OUTPUT_PIN_CLOCK = gpo_clk_ff;
  assign RF_SLOT_NUMBER = slot_ff;
endmodule // rx_frame_filter
`default_nettype wire

/* sim/rx_frame_filter_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_frame_filter_checker #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic CLK, // clock
  input wire logic RST, // synchronous reset
  input wire logic SCLK, // control serial clock
  input wire logic CS_N, // control select
  input wire logic MISO, // control data out
  input wire logic MISO_OE_N, // data out enable
  input wire logic RX_BIT, // received bit
  input wire logic RX_BIT_VALID, // bit strobe
  input wire logic [7:0] FIFO_DATA, // buffered byte
  input wire logic FIFO_VALID, // byte present
  input wire logic FIFO_READY, // byte taken
  input wire logic GENERAL_OUTPUT_PIN_ZERO, // serial data
  input wire logic GENERAL_OUTPUT_PIN_CLOCK, // serial strobe
  input wire logic [7:0] RF_SLOT_NUMBER // channel index
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  a_oe_follows_select: assert property (!$past(RST) |-> MISO_OE_N == $past(CS_N))
    else $error("data out enable does not follow select");
  a_miso_low_phase: assert property ($changed(MISO) |-> !$past(SCLK))
    else $error("data out changed while serial clock high");
  a_slot_after_write: assert property ($changed(RF_SLOT_NUMBER) |-> !$past(CS_N, 2))
    else $error("channel index changed without a write");
  a_reset_state: assert property (disable iff (1'b0) RST |=> RF_SLOT_NUMBER == 8'h00 && !FIFO_VALID && MISO_OE_N)
    else $error("outputs not at reset values");
  a_fifo_data_held: assert property (FIFO_VALID && !FIFO_READY |=> FIFO_DATA == $past(FIFO_DATA) || !FIFO_VALID)
    else $error("buffered byte changed before it was taken");
  a_strobe_cause: assert property (GENERAL_OUTPUT_PIN_CLOCK |-> $past(RX_BIT_VALID))
    else $error("serial strobe without a received bit");
  a_strobe_data: assert property (GENERAL_OUTPUT_PIN_CLOCK |-> GENERAL_OUTPUT_PIN_ZERO == $past(RX_BIT))
    else $error("serial data does not match received bit");
  a_serial_bypass: assert property (GENERAL_OUTPUT_PIN_CLOCK |-> !FIFO_VALID)
    else $error("buffer holds data in serial format");
endmodule // rx_frame_filter_checker
bind rx_frame_filter rx_frame_filter_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_checker (.CLK(CLK), .RST(RST),
  .SCLK(SCLK), .CS_N(CS_N), .MISO(MISO), .MISO_OE_N(MISO_OE_N), .RX_BIT(RX_BIT), .RX_BIT_VALID(RX_BIT_VALID),
  .FIFO_DATA(FIFO_DATA), .FIFO_VALID(FIFO_VALID), .FIFO_READY(FIFO_READY),
  .GENERAL_OUTPUT_PIN_ZERO(GENERAL_OUTPUT_PIN_ZERO), .GENERAL_OUTPUT_PIN_CLOCK(GENERAL_OUTPUT_PIN_CLOCK),
  .RF_SLOT_NUMBER(RF_SLOT_NUMBER));
`default_nettype wire

/* sim/rx_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_tx_model (
  input wire logic CLK, // clock
  output logic RX_BIT, // bit to receiver
  output logic RX_BIT_VALID, // bit strobe
  output logic RX_ABORT // carrier loss
);
  logic [15:0] crc;
  initial
  begin
    RX_BIT = 1'b0;
    RX_BIT_VALID = 1'b0;
    RX_ABORT = 1'b0;
  end
  // released line shows the inverse bit so a stale level never reads as data
  task automatic put(input logic b);
    @(posedge CLK);
    #1;
    RX_BIT = b;
    RX_BIT_VALID = 1'b1;
    crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? rx_filter_pkg::CHECK_POLY : 16'h0000);
    @(posedge CLK);
    #1;
    RX_BIT = ~b;
    RX_BIT_VALID = 1'b0;
  endtask
  task automatic send(input logic [15:0] dl, input logic [7:0] q[$], input logic chk, input logic bad);
    logic [15:0] c;
    for (int i = 15; i >= 0; i--)
      put(dl[i]);
    crc = rx_filter_pkg::CHECK_INIT;
    foreach (q[k])
      for (int i = 7; i >= 0; i--)
        put(q[k][i]);
    c = crc ^ {15'h0000, bad};
    if (chk)
      for (int i = 15; i >= 0; i--)
        put(c[i]);
  endtask
  task automatic lose_carrier;
    @(posedge CLK);
    #1;
    RX_ABORT = 1'b1;
    @(posedge CLK);
    #1;
    RX_ABORT = 1'b0;
  endtask
endmodule // rx_tx_model
`default_nettype wire

/* sim/rx_frame_filter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rx_frame_filter_tb;
  localparam int DEPTH = 8;
  logic clk = 0, rst = 1, sclk = 0, cs_n = 1, mosi = 0, fready = 1;
  logic miso, oe_n, rx_bit, rx_vld, rx_abort, fvalid, gpo, gpo_clk;
  logic [7:0] fdata, slot, v;
  logic [7:0] got[$], none[$], e[$];
  int num_errors = 0, checks = 0, pulses = 0;
  always #4 clk = ~clk;
  rx_frame_filter #(.FIFO_DEPTH(DEPTH)) u_dut (.CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi),
    .MISO(miso), .MISO_OE_N(oe_n), .RX_BIT(rx_bit), .RX_BIT_VALID(rx_vld), .RX_ABORT(rx_abort),
    .RX_RSSI(8'h5C), .FIFO_DATA(fdata), .FIFO_VALID(fvalid), .FIFO_READY(fready),
    .GENERAL_OUTPUT_PIN_ZERO(gpo), .GENERAL_OUTPUT_PIN_CLOCK(gpo_clk), .RF_SLOT_NUMBER(slot));
  rx_tx_model u_tx (.CLK(clk), .RX_BIT(rx_bit), .RX_BIT_VALID(rx_vld), .RX_ABORT(rx_abort));
  always @(posedge clk)
  begin
    if (fvalid === 1'b1 && fready === 1'b1)
      got.push_back(fdata);
    if (gpo_clk === 1'b1)
      pulses++;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    checks++;
    if (g !== x)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      mosi = tx[i];
      tick(3);
      sclk = 1;
      tick(3);
      rx[i] = miso;
      sclk = 0;
    end
  endtask
  task automatic acc(input logic [7:0] h, input logic [7:0] d);
    cs_n = 0;
    tick(2);
    xfer(h, v);
    xfer(d, v);
    tick(3);
    cs_n = 1;
    tick(3);
  endtask
  task automatic match(input string n, input logic [7:0] x[$]);
    tick(12);
    chk(n, 8'(x.size()), 8'(got.size()));
    foreach (x[i])
      if (i < got.size())
        chk(n, x[i], got[i]);
    got = none;
  endtask
  task automatic test_regs;
    logic [7:0] rv[7];
    rv = '{8'hD3, 8'h91, 8'hFF, 8'h04, 8'h45, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      acc(8'h84 + 8'(i), 8'h00);
      chk("reset value", rv[i], v);
    end
    acc(8'hA0, 8'h00);
    chk("unmapped", 8'h00, v);
    acc(8'h07, 8'hFF);
    acc(8'h87, 8'h00);
    chk("filter control", 8'hEF, v);
    acc(8'h08, 8'hFF);
    acc(8'h88, 8'h00);
    chk("format control", 8'h77, v);
    acc(8'h0A, 8'h5A);
    chk("slot number", 8'h5A, slot);
    acc(8'h07, 8'h04);
    acc(8'h08, 8'h45);
  endtask
  task automatic test_filter;
    logic [10:0] t[7];
    t = '{{2'b00, 1'b1, 8'h55}, {2'b01, 1'b1, 8'h42}, {2'b01, 1'b0, 8'h00}, {2'b10, 1'b1, 8'h00},
      {2'b10, 1'b0, 8'hFF}, {2'b11, 1'b1, 8'hFF}, {2'b01, 1'b0, 8'h55}};
    acc(8'h09, 8'h42);
    for (int i = 0; i < 7; i++)
    begin
      acc(8'h07, {6'b000001, t[i][10:9]});
      u_tx.send(16'hD391, '{8'h02, t[i][7:0], 8'h77}, 1'b1, 1'b0);
      e = none;
      if (t[i][8])
        e = '{8'h02, t[i][7:0], 8'h77, 8'h5C, 8'h80};
      match("filtered frame", e);
    end
    acc(8'h07, 8'h04);
  endtask
  task automatic test_limit;
    acc(8'h06, 8'h04);
    u_tx.send(16'hD391, '{8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05}, 1'b1, 1'b0);
    match("long frame", none);
    u_tx.send(16'hD391, '{8'h04, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b1, 1'b0);
    match("limit frame", '{8'h04, 8'h01, 8'h02, 8'h03, 8'h04, 8'h5C, 8'h80});
  endtask
  task automatic test_fixed;
    acc(8'h04, 8'hA5);
    acc(8'h05, 8'h3C);
    acc(8'h06, 8'h03);
    acc(8'h08, 8'h44);
    u_tx.send(16'hD391, '{8'h31, 8'h32, 8'h33}, 1'b1, 1'b0);
    match("old delimiter", none);
    u_tx.send(16'hA53C, '{8'h31, 8'h32, 8'h33}, 1'b1, 1'b0);
    match("fixed frame", '{8'h31, 8'h32, 8'h33, 8'h5C, 8'h80});
    acc(8'h04, 8'hD3);
    acc(8'h05, 8'h91);
    acc(8'h06, 8'hFF);
    acc(8'h08, 8'h45);
  endtask
  task automatic test_flush;
    logic [7:0] c[3];
    c = '{8'h0C, 8'h04, 8'h00};
    for (int i = 0; i < 3; i++)
    begin
      acc(8'h07, c[i]);
      fready = 0;
      u_tx.send(16'hD391, '{8'h02, 8'hAA, 8'hBB}, 1'b1, i != 2);
      fready = 1;
      e = '{8'h02, 8'hAA, 8'hBB};
      if (i == 0)
        e = none;
      if (i == 1)
        e = '{8'h02, 8'hAA, 8'hBB, 8'h5C, 8'h00};
      match("check frame", e);
    end
    acc(8'h07, 8'h04);
  endtask
  task automatic test_overflow;
    acc(8'h08, 8'h46);
    fready = 0;
    e = none;
    for (int i = 0; i < 12; i++)
      e.push_back(8'(i));
    u_tx.send(16'hD391, e, 1'b0, 1'b0);
    u_tx.lose_carrier();
    acc(8'hB5, 8'h00);
    chk("overflow flag", 8'h80, v & 8'h80);
    fready = 1;
    tick(12);
    checks++;
    if (got.size() < DEPTH || got.size() > DEPTH + 3)
    begin
      num_errors++;
      $display("[ERR] kept bytes expected %0d seen %0d", DEPTH, got.size());
    end
    foreach (got[i])
      chk("kept byte", 8'(i), got[i]);
    got = none;
    acc(8'h35, 8'h00);
    acc(8'h08, 8'h45);
  endtask
  task automatic test_serial;
    logic [7:0] f[2];
    f = '{8'h55, 8'h75};
    for (int i = 0; i < 2; i++)
    begin
      acc(8'h08, f[i]);
      pulses = 0;
      u_tx.send(16'hD391, '{8'hA5}, 1'b0, 1'b0);
      tick(4);
      chk("serial strobes", i == 0 ? 8'h18 : 8'h00, 8'(pulses));
      match("serial buffer", none);
    end
    acc(8'h08, 8'h45);
  endtask
  task automatic stop_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    tick(12);
    rst = 0;
    test_regs;
    test_filter;
    test_limit;
    test_fixed;
    test_flush;
    test_overflow;
    test_serial;
    stop_test;
  end
  // the tests need about 7k cycles; this leaves a wide margin
  initial
  begin
    #400000;
    num_errors++;
    stop_test;
  end
endmodule // rx_frame_filter_tb
`default_nettype wire
